// ===== design/aas_chan_filter.sv
// Per-channel post-processing: bypass, smoothing filter and hysteresis
module aas_chan_filter
  import aas_pkg::*;
#(
  parameter int W = ADC_W,
  parameter int SHIFT = FILT_SHIFT
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic sample_valid_in,
  input wire logic [W-1:0] sample_in,
  input wire logic [1:0] mode_in,
  output logic [W-1:0] value_out
);

  logic [W-1:0] filt_reg;
  logic [W-1:0] filt_next;
  logic [W-1:0] value_reg;
  logic [W-1:0] thr;
  logic primed_reg;
  logic signed [W:0] delta;
  logic signed [W:0] step;

  function automatic logic [W-1:0] absdiff(input logic [W-1:0] a,
                                           input logic [W-1:0] b);
    return (a > b) ? W'(a - b) : W'(b - a);
  endfunction

  // ****************************************
  // Smoothing filter
  // ****************************************
  // First-order low pass; the arithmetic shift floors, so a residue
  // below 2**SHIFT LSBs may remain, which hysteresis then hides
  always_comb begin
    delta = $signed({1'b0, sample_in}) - $signed({1'b0, filt_reg});
    step = delta >>> SHIFT;
    filt_next = primed_reg ?
      W'($signed({1'b0, filt_reg}) + step) : sample_in;
    thr = (mode_in == MODE_HYST1) ? W'(HYST1_LSB) : W'(HYST2_LSB);
  end

  // Filter state runs in every mode so a mode switch has no start-up step
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      filt_reg <= '0;
      primed_reg <= 1'b0;
    end else if (sample_valid_in) begin
      filt_reg <= filt_next;
      primed_reg <= 1'b1;
    end
  end

  // ****************************************
  // Reported value
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      value_reg <= '0;
    end else if (sample_valid_in) begin
      unique case (mode_in)
        MODE_BYPASS: value_reg <= sample_in;
        MODE_FILT: value_reg <= filt_next;
        MODE_HYST1, MODE_HYST2: begin
          if (absdiff(filt_next, value_reg) > thr) begin
            value_reg <= filt_next;
          end
        end
      endcase
    end
  end

  assign value_out = value_reg;

  // ****************************************
  // Checks
  // ****************************************
  bypass_pass_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    sample_valid_in && mode_in == MODE_BYPASS
    |=> value_out == $past(sample_in))
    else $error("bypass value does not follow raw sample");

  filt_track_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    sample_valid_in && mode_in == MODE_FILT
    |=> value_out == filt_reg
        && absdiff(value_out, $past(sample_in))
           <= absdiff($past(filt_reg), $past(sample_in)))
    else $error("filtered value differs from filter state");

  hyst_step_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    $changed(value_out) && $past(mode_in[1])
    |-> absdiff(value_out, $past(value_out)) > $past(thr))
    else $error("hysteresis output moved by too little");

  hyst_move_c: cover property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    $changed(value_out) && $past(mode_in) == MODE_HYST2);

endmodule

// ===== design/aas_pkg.sv
// Constants shared by the auxiliary converter sequencer and its filters
// Function
// - Each of the four control-input channels yields a 10-bit result.
// - One shared converter is multiplexed over the channels in rotation.
// - A conversion starts every 3584 clocks, so each channel every 14336.
// - The filter select register holds 2 bits per channel, 15:8 reserved.
// - Selector 00 bypass, 01 filter, 10 and 11 hysteresis; reset to 00.
// - A pin feeds the converter only while its 4-bit mode is 1101.
package aas_pkg;

  // ****************************************
  // Sizes and timing
  // ****************************************
  localparam int ADC_W = 10;
  localparam int NUM_CH = 4;
  localparam int SEL_W = 2;
  localparam int REG_W = 16;
  localparam int SLOT_CYCLES = 3584;
  localparam int CH_REFRESH_CYCLES = SLOT_CYCLES * NUM_CH;
  localparam int FILT_SHIFT = 2;
  localparam int HYST1_LSB = 1;
  localparam int HYST2_LSB = 2;

  // ****************************************
  // Register map and field values
  // ****************************************
  localparam logic [15:0] PIN_MODE_BASE = 16'hE204;
  localparam logic [15:0] FILT_SEL_ADDR = 16'hE224;
  localparam logic [15:0] RESULT_BASE = 16'hE228;
  localparam int PIN_MODE_W = 4;
  localparam int FILT_SEL_W = 8;
  localparam logic [7:0] FILT_SEL_RST = 8'h00;
  localparam logic [3:0] PIN_MODE_RST = 4'h0;
  localparam logic [3:0] PIN_MODE_AUX = 4'hD;
  localparam logic [1:0] MODE_BYPASS = 2'h0;
  localparam logic [1:0] MODE_FILT = 2'h1;
  localparam logic [1:0] MODE_HYST1 = 2'h2;
  localparam logic [1:0] MODE_HYST2 = 2'h3;

  // Channel 0 sits in the top pair of the select field
  function automatic int sel_lsb(input int ch);
    return (NUM_CH - 1 - ch) * SEL_W;
  endfunction

endpackage

// ===== design/aas_sequencer.sv
// Auxiliary converter sequencer with register bank and channel filters
module aas_sequencer
  import aas_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [REG_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [REG_W-1:0] reg_rdata_out,
  output logic conv_start_out,
  output logic [1:0] conv_mux_sel_out,
  input wire logic conv_done_in,
  input wire logic [ADC_W-1:0] conv_result_in,
  output logic [ADC_W-1:0] aux_channel_zero_out,
  output logic [ADC_W-1:0] aux_channel_one_out,
  output logic [ADC_W-1:0] aux_channel_two_out,
  output logic [ADC_W-1:0] aux_channel_three_out
);

  typedef enum logic {SEQ_IDLE, SEQ_WAIT} aas_seq_state_type;

  // ****************************************
  // Declarations
  // ****************************************
  logic [FILT_SEL_W-1:0] filt_sel_reg;
  logic [PIN_MODE_W-1:0] pin_mode_reg [NUM_CH];
  logic [REG_W-1:0] rdata_reg;
  logic [REG_W-1:0] rdata_next;
  logic [11:0] slot_cnt_reg;
  logic slot_tick;
  logic [1:0] ch_reg;
  logic [1:0] mux_reg;
  logic [1:0] conv_ch_reg;
  logic start_reg;
  logic slot_pulse_reg;
  aas_seq_state_type state_reg;
  logic [NUM_CH-1:0] sample_valid;
  logic [ADC_W-1:0] value [NUM_CH];
  logic [2:0] pin_idx;
  logic [2:0] res_idx;

  // Offset of addr into a block of NUM_CH registers, or 4 if outside
  function automatic logic [2:0] block_idx(input logic [15:0] addr,
                                           input logic [15:0] base);
    logic [15:0] off;
    off = 16'(addr - base);
    return (addr >= base && off < 16'(NUM_CH)) ? 3'(off) : 3'h4;
  endfunction

  function automatic logic pin_is_aux(input logic [3:0] mode);
    return mode == PIN_MODE_AUX;
  endfunction

  assign pin_idx = block_idx(reg_addr_in, PIN_MODE_BASE);
  assign res_idx = block_idx(reg_addr_in, RESULT_BASE);

  // ****************************************
  // Register writes
  // ****************************************
  // Only the eight selector bits are stored; the rest read as zero
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      filt_sel_reg <= FILT_SEL_RST;
    end else if (reg_wr_in && reg_addr_in == FILT_SEL_ADDR) begin
      filt_sel_reg <= reg_wdata_in[FILT_SEL_W-1:0];
    end
  end

  // Pin modes for the four pins that can reach the converter
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < NUM_CH; i++) begin
        pin_mode_reg[i] <= PIN_MODE_RST;
      end
    end else if (reg_wr_in && !pin_idx[2]) begin
      pin_mode_reg[pin_idx[1:0]] <= reg_wdata_in[PIN_MODE_W-1:0];
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  // Unmapped addresses read as zero; the data stand for one cycle only
  always_comb begin
    rdata_next = '0;
    if (reg_rd_in) begin
      if (reg_addr_in == FILT_SEL_ADDR) begin
        rdata_next = REG_W'(filt_sel_reg);
      end else if (!pin_idx[2]) begin
        rdata_next = REG_W'(pin_mode_reg[pin_idx[1:0]]);
      end else if (!res_idx[2]) begin
        rdata_next = REG_W'(value[res_idx[1:0]]);
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_out = rdata_reg;

  // ****************************************
  // Conversion slot timing
  // ****************************************
  // Free-running divider: one slot per SLOT_CYCLES clocks
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      slot_cnt_reg <= '0;
    end else if (slot_tick) begin
      slot_cnt_reg <= '0;
    end else begin
      slot_cnt_reg <= slot_cnt_reg + 12'h001;
    end
  end

  assign slot_tick = slot_cnt_reg == 12'(SLOT_CYCLES - 1);

  // Rotation advances even when a pin is not in converter mode, so each
  // channel keeps its fixed CH_REFRESH_CYCLES refresh period
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      ch_reg <= 2'h0;
      mux_reg <= 2'h0;
      start_reg <= 1'b0;
      slot_pulse_reg <= 1'b0;
    end else begin
      slot_pulse_reg <= slot_tick;
      start_reg <= slot_tick && pin_is_aux(pin_mode_reg[ch_reg]);
      if (slot_tick) begin
        mux_reg <= ch_reg;
        ch_reg <= ch_reg + 2'h1;
      end
    end
  end

  assign conv_start_out = start_reg;
  assign conv_mux_sel_out = mux_reg;

  // ****************************************
  // Result capture
  // ****************************************
  // A done outside a pending conversion is ignored; a new slot restarts
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      state_reg <= SEQ_IDLE;
    end else begin
      unique case (state_reg)
        SEQ_IDLE: begin
          if (start_reg) begin
            state_reg <= SEQ_WAIT;
          end
        end
        SEQ_WAIT: begin
          if (conv_done_in && !start_reg) begin
            state_reg <= SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // Channel of the pending conversion; a late answer that meets the next
  // slot's mux step still lands in the channel that was started
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      conv_ch_reg <= 2'h0;
    end else if (start_reg) begin
      conv_ch_reg <= mux_reg;
    end
  end

  always_comb begin
    sample_valid = '0;
    if (state_reg == SEQ_WAIT && conv_done_in) begin
      sample_valid[conv_ch_reg] = 1'b1;
    end
  end

  // ****************************************
  // Per-channel post-processing
  // ****************************************
  for (genvar g = 0; g < NUM_CH; g++) begin : gen_ch
    aas_chan_filter #(
      .W(ADC_W),
      .SHIFT(FILT_SHIFT)
    ) u_filt (
      .sys_clk_in(sys_clk_in),
      .resetn_in(resetn_in),
      .sample_valid_in(sample_valid[g]),
      .sample_in(conv_result_in),
      .mode_in(filt_sel_reg[sel_lsb(g) +: SEL_W]),
      .value_out(value[g])
    );
  end

  assign aux_channel_zero_out = value[0];
  assign aux_channel_one_out = value[1];
  assign aux_channel_two_out = value[2];
  assign aux_channel_three_out = value[3];

  // ****************************************
  // Check helpers
  // ****************************************
  logic [15:0] gap_reg;
  logic [1:0] prev_mux_reg;
  logic seen_reg;

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      gap_reg <= '0;
      prev_mux_reg <= 2'h0;
      seen_reg <= 1'b0;
    end else if (slot_pulse_reg) begin
      gap_reg <= '0;
      prev_mux_reg <= mux_reg;
      seen_reg <= 1'b1;
    end else begin
      gap_reg <= gap_reg + 16'h0001;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  slot_period_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    slot_pulse_reg && seen_reg |-> gap_reg == 16'(SLOT_CYCLES - 1))
    else $error("conversion slots not 3584 clocks apart");

  first_slot_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    !seen_reg |-> gap_reg <= 16'(SLOT_CYCLES))
    else $error("first conversion slot came late");

  mux_rotate_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    slot_pulse_reg && seen_reg |-> mux_reg == 2'(prev_mux_reg + 2'h1))
    else $error("channel multiplexer did not step in rotation");

  pin_gate_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    slot_pulse_reg |->
      conv_start_out == pin_is_aux(pin_mode_reg[mux_reg]))
    else $error("start does not match pin converter mode");

  sel_reset_a: assert property (
    @(posedge sys_clk_in)
    !resetn_in |=> filt_sel_reg == FILT_SEL_RST)
    else $error("filter selectors not cleared by reset");

  sel_read_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    reg_rd_in && reg_addr_in == FILT_SEL_ADDR
    |=> reg_rdata_out[15:8] == 8'h00
        && reg_rdata_out[7:0] == $past(filt_sel_reg))
    else $error("filter select read back wrong");

  result_route_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    sample_valid[0] && filt_sel_reg[7:6] == MODE_BYPASS
    |=> aux_channel_zero_out == $past(conv_result_in))
    else $error("channel zero result not delivered");

  read_once_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    !reg_rd_in |=> reg_rdata_out == '0)
    else $error("read data stood beyond its cycle");

  start_slot_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    conv_start_out |-> slot_cnt_reg == 12'h000 && slot_pulse_reg)
    else $error("conversion start outside its slot");

  start_pulse_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    conv_start_out |=> !conv_start_out)
    else $error("conversion start longer than one cycle");

  mux_hold_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    !slot_pulse_reg |-> $stable(conv_mux_sel_out))
    else $error("channel select moved inside a slot");

  pin_write_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    reg_wr_in && reg_addr_in == PIN_MODE_BASE
    |=> pin_mode_reg[0] == $past(reg_wdata_in[PIN_MODE_W-1:0]))
    else $error("pin zero mode write did not land");

  start_c: cover property (
    @(posedge sys_clk_in) disable iff (!resetn_in) conv_start_out);

  sample_c: cover property (
    @(posedge sys_clk_in) disable iff (!resetn_in) sample_valid[3]);

  sel_write_c: cover property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    reg_wr_in && reg_addr_in == FILT_SEL_ADDR);

endmodule

// ===== verif/aas_conv_model.sv
// Behavioural converter standing on the far side of the sequencer
module aas_conv_model (
  input wire logic sys_clk_in,
  input wire logic start_in,
  input wire logic [1:0] sel_in,
  input wire logic [39:0] levels_in,
  input wire logic [11:0] delay_in,
  input wire logic spurious_in,
  output logic done_out,
  output logic [9:0] result_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Conversion
  // ********
  logic done_reg = 1'b0;
  logic [9:0] res_reg = 10'h155;
  logic pend_reg = 1'b0;
  logic [11:0] cnt_reg = 12'h000;
  logic [1:0] ch_reg = 2'h0;
  assign done_out = done_reg;
  assign result_out = res_reg;
  // Result bus flips when idle so a stale sample cannot pass as fresh
  always_ff @(posedge sys_clk_in) begin
    done_reg <= 1'b0;
    res_reg <= ~res_reg;
    if (start_in) begin
      pend_reg <= 1'b1;
      ch_reg <= sel_in;
      cnt_reg <= delay_in;
    end else if (pend_reg && cnt_reg <= 12'h001) begin
      pend_reg <= 1'b0;
      done_reg <= 1'b1;
      res_reg <= levels_in[ch_reg*10 +: 10]; // Level at answer time
    end else if (pend_reg) begin
      cnt_reg <= cnt_reg - 12'h001;
    end else if (spurious_in) begin
      done_reg <= 1'b1; // Stray answer, only when commanded
    end
  end
endmodule

// ===== verif/aas_sequencer_tb.sv
// Self-checking bench for the auxiliary converter sequencer
module aas_sequencer_tb
  import aas_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Signals and instances
  // ********
  localparam int NSLOT = 20;
  localparam logic [7:0] SEL_VAL = 8'h1B;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic [15:0] bus_wdata = 16'h0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [15:0] bus_rdata;
  logic conv_start;
  logic [1:0] conv_sel;
  logic conv_done;
  logic [9:0] conv_result;
  wire [39:0] outs;
  logic [39:0] levels = 40'h0;
  logic [11:0] delay = 12'h001;
  logic spurious = 1'b0;
  logic [9:0] e_filt [4];
  logic [9:0] e_held [4] = '{default: 10'h000};
  logic [9:0] e_out [4] = '{default: 10'h000};
  logic [9:0] e_in [4];
  bit seeded [4];
  int cyc = 0;
  int n_starts = 0;
  int num_errors = 0;
  int comparisons = 0;

  aas_sequencer i_aas_sequencer (
    .sys_clk_in(sys_clk),
    .resetn_in(resetn),
    .reg_addr_in(bus_addr),
    .reg_wdata_in(bus_wdata),
    .reg_wr_in(bus_wr),
    .reg_rd_in(bus_rd),
    .reg_rdata_out(bus_rdata),
    .conv_start_out(conv_start),
    .conv_mux_sel_out(conv_sel),
    .conv_done_in(conv_done),
    .conv_result_in(conv_result),
    .aux_channel_zero_out(outs[9:0]),
    .aux_channel_one_out(outs[19:10]),
    .aux_channel_two_out(outs[29:20]),
    .aux_channel_three_out(outs[39:30])
  );

  aas_conv_model i_aas_conv_model (
    .sys_clk_in(sys_clk),
    .start_in(conv_start),
    .sel_in(conv_sel),
    .levels_in(levels),
    .delay_in(delay),
    .spurious_in(spurious),
    .done_out(conv_done),
    .result_out(conv_result)
  );

  // Free-running 100 MHz clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // Cycle count and start count; slot timing is judged against these
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (conv_start === 1'b1) n_starts <= n_starts + 1;
  end

  // ********
  // Tasks and functions
  // ********
  task automatic wrap_up();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Bounded wait until the bench cycle count reaches t
  task automatic wait_cyc(input int t);
    int n = 0;
    while (cyc < t) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 4000) begin
        num_errors++;
        wrap_up();
      end
    end
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe, then return to zero
  task automatic reg_rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1;
    check("read data", bus_rdata, exp);
    @(posedge sys_clk);
    #1;
    check("idle read data", bus_rdata, 16'h0000);
  endtask

  // Expected channel value: smoothing always tracks, mode picks output
  function automatic void apply(input int k, input logic [9:0] x);
    logic signed [10:0] d;
    int m;
    int gap;
    m = int'(SEL_VAL >> (6 - 2 * k)) & 3;
    d = $signed({1'b0, x}) - $signed({1'b0, e_filt[k]});
    e_filt[k] = seeded[k] ? e_filt[k] + 10'(d >>> 2) : x;
    seeded[k] = 1'b1;
    gap = int'(e_filt[k]) - int'(e_held[k]);
    if (gap < 0) gap = -gap;
    if (m > 1 && gap > m - 1) e_held[k] = e_filt[k];
    e_out[k] = (m == 0) ? x : (m == 1) ? e_filt[k] : e_held[k];
  endfunction

  // ********
  // Sequence
  // ********
  initial begin
    logic [9:0] x;
    int t_next;
    int k;
    int n;
    void'($urandom(88));
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    // Reset values, reserved bits and an unmapped address
    for (k = 0; k < 4; k++) begin
      reg_rd(PIN_MODE_BASE + 16'(k), 16'h0000);
      reg_rd(RESULT_BASE + 16'(k), 16'h0000);
    end
    reg_rd(FILT_SEL_ADDR, 16'h0000);
    reg_wr(FILT_SEL_ADDR, {8'($urandom), SEL_VAL});
    reg_rd(FILT_SEL_ADDR, {8'h00, SEL_VAL});
    reg_wr(FILT_SEL_ADDR + 16'h0001, 16'($urandom));
    reg_rd(FILT_SEL_ADDR + 16'h0001, 16'h0000);
    reg_rd(FILT_SEL_ADDR, {8'h00, SEL_VAL});
    // Pin two left in a digital mode for the first rotation
    for (k = 0; k < 4; k++) begin
      x = (k == 2) ? 10'h007 : {6'($urandom), 4'hD};
      reg_wr(PIN_MODE_BASE + 16'(k), {6'($urandom), x});
    end
    reg_rd(PIN_MODE_BASE + 16'h0002, 16'h0007);
    n = 0;
    #1;
    while (conv_start !== 1'b1) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 4000) begin
        num_errors++;
        wrap_up();
      end
    end
    t_next = cyc;
    // Slot by slot: timing, rotation, prompt and slow answers
    for (int s = 0; s < NSLOT; s++) begin
      k = s % 4;
      wait_cyc(t_next);
      check("start", 16'(conv_start), (s == 2) ? 16'h0 : 16'h1);
      check("mux select", 16'(conv_sel), 16'(k));
      @(posedge sys_clk);
      if (s != 2) begin
        x = (s < 8) ? 10'($urandom) :
            e_in[k] + 10'($urandom_range(6)) - 10'h003;
        e_in[k] = x;
        levels[k*10 +: 10] <= x;
        apply(k, x);
      end else begin
        spurious <= 1'b1; // Stray done with nothing pending
        @(posedge sys_clk);
        spurious <= 1'b0;
        reg_wr(PIN_MODE_BASE + 16'h0002, 16'hFFFD);
      end
      t_next = t_next + SLOT_CYCLES;
      wait_cyc(t_next - 2);
      check("value", 16'(outs[k*10 +: 10]), 16'(e_out[k]));
      @(posedge sys_clk);
      delay <= (s == NSLOT - 1) ? 12'hFFF :
               (s % 2) ? 12'h001 : 12'(1 + $urandom_range(3400));
    end
    check("start count", 16'(n_starts), 16'(NSLOT - 1));
    for (k = 0; k < 4; k++) begin
      reg_rd(RESULT_BASE + 16'(k), {6'h00, e_out[k]});
      reg_rd(PIN_MODE_BASE + 16'(k), 16'h000D);
    end
    wrap_up();
  end
endmodule
